// *** src/indirect_mmd_register_portal.sv ***
// What this block does
// - Five-bit device field selects the device for later data register accesses in modes 01, 10 and 11.
// - Mode 00 makes the data register hold the target register address.
// - Any other mode makes data register accesses reach the selected register's data.
// - Mode 01 leaves the register address unchanged after data accesses.
// - Mode 10 advances the register address after every data read and write.
// - Mode 11 advances the register address after data writes only.
// - Burst read in mode 10 returns consecutive registers on successive reads.
`include "portal_consts.svh"
module indirect_mmd_register_portal
#(
  parameter int DEVS = 4,
  parameter int REGS = 32
)
(
  input wire logic I_CORE_CLK,
  input wire logic I_ARST_N,
  input wire portal_pkg::mgmt_req_t I_REQ,
  output logic [15:0] O_RDATA,
  output logic O_RVALID
);
  import portal_pkg::*;

  // Control reset image, sliced below so the field positions live in one place
  localparam logic [15:0] CTRL_INIT = `CTRL_RESET;

  // Address decode; both portal registers share it
  function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] offset);
    return addr == offset;
  endfunction

  // Portal state: control fields, address holder and the read return path
  portal_mode_t mode_reg, mode_next;
  logic [4:0] dev_reg, dev_next;
  logic [15:0] raddr_reg, raddr_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic ctrl_hit, data_hit, data_mode;
  ext_req_t ext;
  logic [15:0] ext_rdata;

  // Any other address is ignored, so a stray access cannot move portal state
  assign ctrl_hit = reg_hit(I_REQ.addr, `CTRL_OFFSET);
  assign data_hit = reg_hit(I_REQ.addr, `DATA_OFFSET);
  assign data_mode = mode_reg != MODE_REGISTER;

  // Request toward the extended space, device from control register
  always_comb
  begin
    ext.dev = dev_reg;
    ext.reg_addr = raddr_reg;
    ext.wdata = I_REQ.wdata;
    ext.wr = data_hit && I_REQ.wr && data_mode;
    ext.rd = data_hit && I_REQ.rd && data_mode;
  end

  extended_store #(.DEVS(DEVS), .REGS(REGS)) u_store
  (
    .i_clk(I_CORE_CLK),
    .i_arst_n(I_ARST_N),
    .i_req(ext),
    .o_rdata(ext_rdata)
  );

  // Next state of the control register; only a control write changes it
  always_comb
  begin
    mode_next = mode_reg;
    dev_next = dev_reg;
    if (I_REQ.wr && ctrl_hit)
    begin
      // Reserved middle bits are dropped, so they cannot disturb anything
      mode_next = portal_mode_t'(I_REQ.wdata[`MODE_MSB:`MODE_LSB]);
      dev_next = I_REQ.wdata[`DEV_MSB:`DEV_LSB];
    end
  end

  // Register the control fields
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      mode_reg <= portal_mode_t'(CTRL_INIT[`MODE_MSB:`MODE_LSB]);
      dev_reg <= CTRL_INIT[`DEV_MSB:`DEV_LSB];
    end
    else
    begin
      mode_reg <= mode_next;
      dev_reg <= dev_next;
    end
  end

  // Next state of the address holder and read data
  always_comb
  begin
    raddr_next = raddr_reg;
    rdata_next = rdata_reg;
    rvalid_next = I_REQ.rd && (ctrl_hit || data_hit);
    if (I_REQ.rd && ctrl_hit)
    begin
      rdata_next = {mode_reg, 9'h000, dev_reg};
    end
    if (data_hit && !data_mode)
    begin
      if (I_REQ.wr)
      begin
        raddr_next = I_REQ.wdata;
      end
      if (I_REQ.rd)
      begin
        rdata_next = raddr_reg;
      end
    end
    else if (data_hit && (I_REQ.wr || I_REQ.rd))
    begin
      if (I_REQ.rd)
      begin
        rdata_next = ext_rdata;
      end
      case (mode_reg)
        MODE_DATA_HOLD: raddr_next = raddr_reg;
        MODE_DATA_INC_RW: raddr_next = raddr_reg + `REG_INC;
        MODE_DATA_INC_WR:
        begin
          if (I_REQ.wr)
          begin
            raddr_next = raddr_reg + `REG_INC;
          end
        end
        default: raddr_next = raddr_reg;
      endcase
    end
  end

  // Register address holder and read data; read data holds until the next read
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      raddr_reg <= `DATA_RESET;
      rdata_reg <= `DATA_RESET;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      raddr_reg <= raddr_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Outputs come straight from flip-flops
  assign O_RDATA = rdata_reg;
  assign O_RVALID = rvalid_reg;

  // Control register: device and mode load on a control write and hold otherwise
  a_dev_select: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    I_REQ.wr && ctrl_hit |=> dev_reg == $past(I_REQ.wdata[4:0])) else $error("device select not loaded");
  a_dev_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    !(I_REQ.wr && ctrl_hit) |=> $stable(dev_reg)) else $error("device select changed");
  a_mode_load: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    I_REQ.wr && ctrl_hit |=> mode_reg == $past(I_REQ.wdata[`MODE_MSB:`MODE_LSB]))
    else $error("operation mode not loaded");
  // Reserved control bits always read back as zero
  a_reserved_read: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    I_REQ.rd && ctrl_hit |=> O_RDATA[13:5] == 9'h000) else $error("reserved bits nonzero");
  // Unmapped addresses must leave the control fields and the address holder alone
  a_unmapped_quiet: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    !(ctrl_hit || data_hit) |=> $stable({mode_reg, dev_reg, raddr_reg}))
    else $error("unmapped access changed state");

  // Register mode: the data register is the address holder
  a_addr_load: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    I_REQ.wr && data_hit && mode_reg == MODE_REGISTER |=> raddr_reg == $past(I_REQ.wdata)) else $error("address not loaded");
  a_addr_read: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    I_REQ.rd && data_hit && mode_reg == MODE_REGISTER |=> O_RDATA == $past(raddr_reg) && O_RVALID)
    else $error("address read wrong");

  // Data modes: reads come from the selected extended register
  a_data_path: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    I_REQ.rd && data_hit && data_mode |=> O_RDATA == $past(ext_rdata) && O_RVALID) else $error("data read wrong");
  // Read valid is high in the cycle after each read; back-to-back reads keep it high
  a_rvalid_on: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    I_REQ.rd && (ctrl_hit || data_hit) |=> O_RVALID) else $error("read valid missing");
  a_rvalid_off: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    !(I_REQ.rd && (ctrl_hit || data_hit)) |=> !O_RVALID) else $error("read valid without read");
  // Read data must stand until the next read, since the host may sample it late
  a_rdata_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    !(I_REQ.rd && (ctrl_hit || data_hit)) |=> $stable(O_RDATA))
    else $error("read data changed without read");

  // Post-increment: the address moves only on data accesses, as the mode allows
  a_addr_quiet: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    !data_hit |=> $stable(raddr_reg)) else $error("address moved without access");
  a_hold_addr: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    data_hit && mode_reg == MODE_DATA_HOLD |=> $stable(raddr_reg)) else $error("address moved in hold mode");
  a_inc_rw: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    data_hit && (I_REQ.rd || I_REQ.wr) && mode_reg == MODE_DATA_INC_RW |=> raddr_reg == $past(raddr_reg) + 16'h0001)
    else $error("no increment on access");
  a_inc_wr_only: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    data_hit && I_REQ.rd && !I_REQ.wr && mode_reg == MODE_DATA_INC_WR |=> $stable(raddr_reg))
    else $error("read advanced address");
  a_inc_on_wr: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    data_hit && I_REQ.wr && mode_reg == MODE_DATA_INC_WR |=> raddr_reg == $past(raddr_reg) + 16'h0001)
    else $error("write did not advance address");

  // Main scenarios: burst read, address then data, write with increment, reserved bits, plain write
  c_burst: cover property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    (I_REQ.rd && data_hit && mode_reg == MODE_DATA_INC_RW)[*3]);
  c_addr_then_data: cover property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    I_REQ.wr && data_hit && !data_mode ##[1:8] I_REQ.wr && data_hit && mode_reg == MODE_DATA_HOLD);
  c_wr_inc: cover property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    I_REQ.wr && data_hit && mode_reg == MODE_DATA_INC_WR);
  c_reserved_bits: cover property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    I_REQ.wr && ctrl_hit && I_REQ.wdata[13:5] != 9'h000);
  c_hold_write: cover property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
    I_REQ.wr && data_hit && mode_reg == MODE_DATA_HOLD);
endmodule // indirect_mmd_register_portal

// *** src/portal_consts.svh ***
`ifndef PORTAL_CONSTS_SVH
`define PORTAL_CONSTS_SVH
`define CTRL_OFFSET 5'h0d
`define DATA_OFFSET 5'h0e
`define MODE_MSB 15
`define MODE_LSB 14
`define DEV_MSB 4
`define DEV_LSB 0
`define CTRL_RESET 16'h0000
`define DATA_RESET 16'h0000
`define REG_INC 16'h0001
`endif

// *** src/portal_pkg.sv ***
package portal_pkg;
  typedef enum logic [1:0]
  {
    MODE_REGISTER,
    MODE_DATA_HOLD,
    MODE_DATA_INC_RW,
    MODE_DATA_INC_WR
  } portal_mode_t;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef struct packed
  {
    logic [4:0] dev;
    logic [15:0] reg_addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ext_req_t;
endpackage

// *** src/extended_store.sv ***
`include "portal_consts.svh"
// Backing storage for the extended register space, indexed by device and low register address bits
module extended_store
#(
  parameter int DEVS = 4,
  parameter int REGS = 32
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire portal_pkg::ext_req_t i_req,
  output logic [15:0] o_rdata
);
  import portal_pkg::*;

  localparam int DW = $clog2(DEVS);
  localparam int RW = $clog2(REGS);
  logic [15:0] mem_reg [DEVS*REGS];
  logic [15:0] mem_next [DEVS*REGS];
  logic [DW+RW-1:0] idx;

  // Out-of-range devices fold onto the implemented ones; a real part would decode further
  assign idx = {i_req.dev[DW-1:0], i_req.reg_addr[RW-1:0]};
  assign o_rdata = mem_reg[idx];

  // Write update
  always_comb
  begin
    mem_next = mem_reg;
    if (i_req.wr)
    begin
      mem_next[idx] = i_req.wdata;
    end
  end

  // Register the storage
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (int k = 0; k < DEVS*REGS; k++)
      begin
        mem_reg[k] <= `DATA_RESET;
      end
    end
    else
    begin
      mem_reg <= mem_next;
    end
  end
endmodule // extended_store

// *** test/host_model.sv ***
// Management host: one access per cycle on the request struct
module host_model
(
  input wire logic i_clk,
  output portal_pkg::mgmt_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import portal_pkg::*;
  initial o_req = '0;
  // Launched 1 ns after an edge and held through the next edge, so no race with sampling
  task automatic op(input logic w, input logic [4:0] a, input logic [15:0] d);
    o_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_clk);
    #1;
  endtask
endmodule // host_model

// *** test/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import portal_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  mgmt_req_t req;
  logic [15:0] rdata;
  logic rvalid;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 49;
  logic [15:0] mem [4][32];
  logic [1:0] mode;
  logic [4:0] dev;
  logic [15:0] ra;
  logic [31:0] r;
  always #25 clk = ~clk;
  host_model host_model_i (.i_clk(clk), .o_req(req));
  indirect_mmd_register_portal indirect_mmd_register_portal_i
  (
    .I_CORE_CLK(clk),
    .I_ARST_N(rst_n),
    .I_REQ(req),
    .O_RDATA(rdata),
    .O_RVALID(rvalid)
  );
  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Model state after any reset
  task automatic model_reset;
    foreach (mem[i, j])
      mem[i][j] = 16'h0000;
    mode = 2'h0;
    dev = 5'h00;
    ra = 16'h0000;
  endtask
  // One access; the model's state before it gives the expected read value
  task automatic acc(logic w, logic [4:0] a, logic [15:0] d);
    logic [15:0] e;
    e = 16'h0000;
    host_model_i.op(w, a, d);
    if (a == 5'h0d)
    begin
      e = {mode, 9'h000, dev};
      if (w)
      begin
        mode = d[15:14];
        dev = d[4:0];
      end
    end
    else if (a == 5'h0e && mode == 2'h0)
    begin
      e = ra;
      if (w)
        ra = d;
    end
    else if (a == 5'h0e)
    begin
      e = mem[dev[1:0]][ra[4:0]];
      if (w)
        mem[dev[1:0]][ra[4:0]] = d;
      if (mode == 2'h2 || (mode == 2'h3 && w))
        ra = ra + 16'h0001;
    end
    chk("rvalid", {15'h0000, !w && (a == 5'h0d || a == 5'h0e)}, {15'h0000, rvalid});
    if (!w && (a == 5'h0d || a == 5'h0e))
      chk("rdata", e, rdata);
  endtask
  // Watchdog: about three and a half times the expected run
  initial
  begin
    #(50 * 1200);
    miscompares++;
    stop_test;
  end
  initial
  begin
    model_reset;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    acc(1'b0, 5'h0d, 16'h0000);
    acc(1'b0, 5'h0e, 16'h0000);
    $display("reset values done");
    acc(1'b1, 5'h0d, 16'h0002);
    acc(1'b1, 5'h0e, 16'h0010);
    acc(1'b1, 5'h0d, 16'h4002);
    acc(1'b1, 5'h0e, 16'h0001);
    acc(1'b0, 5'h0e, 16'h0000);
    $display("single write done");
    acc(1'b1, 5'h0d, 16'h0002);
    acc(1'b1, 5'h0e, 16'h0011);
    acc(1'b1, 5'h0d, 16'h8002);
    repeat (3) acc(1'b0, 5'h0e, 16'h0000);
    $display("burst read done");
    // Random mix: every mode, reserved bits, unmapped addresses, back to back
    repeat (300)
    begin
      r = $random(seed);
      acc(r[0], r[2] ? 5'h0e : (r[3] ? 5'h0d : r[8:4]), r[31:16]);
    end
    $display("random mix done");
    // Mid-run reset: everything written so far must be gone
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("rdata in reset", 16'h0000, rdata);
    chk("rvalid in reset", 16'h0000, {15'h0000, rvalid});
    rst_n = 1'b1;
    model_reset;
    acc(1'b0, 5'h0d, 16'h0000);
    acc(1'b0, 5'h0e, 16'h0000);
    acc(1'b1, 5'h0d, 16'h4002);
    acc(1'b0, 5'h0e, 16'h0000);
    $display("mid-run reset done");
    stop_test;
  end
endmodule // testbench
